// File: rtl/cprb_pkg.sv
// Notes on behaviour
// - armed clock-hold stops execution, enters clock mode
// - clock-hold works only right after arming
// - armed ram-backup enters backup state, held until wake
// - unarmed ram-backup is a no-operation, pc advances
// - rotate right: carry into bit3, bit0 to carry
// - bit clear zeroes one addressed nibble bit
package cprb_pkg;

  // ==========================================================
  // widths
  localparam int INSTR_W = 10;           // instruction word width
  localparam int ACC_W   = 4;            // accumulator / ram nibble width
  localparam int DP_W    = 7;            // data pointer width

  // ==========================================================
  // instruction codes
  localparam logic [9:0] OP_NOP        = 10'h000; // no-operation
  localparam logic [9:0] OP_CLOCK_HOLD = 10'h002; // clock_hold_instruction
  localparam logic [9:0] OP_RAM_BACKUP = 10'h008; // ram_backup_instruction
  localparam logic [9:0] OP_ARM        = 10'h05b; // power_down_arm_instruction
  localparam logic [9:0] OP_ROTATE     = 10'h01d; // rotate_right_through_carry
  localparam logic [9:0] OP_CARRY_CLR  = 10'h006; // carry_clear
  localparam logic [9:0] OP_PORTC_CLR  = 10'h28c; // output_port_c_clear
  localparam logic [9:0] OP_BIT_CLR    = 10'h04c; // memory_bit_clear, low 2 bits = bit
  localparam logic [9:0] BIT_CLR_MASK  = 10'h3fc; // compare mask for bit clear
  localparam int         BIT_SEL_LSB   = 0;       // bit select field position

  // ==========================================================
  // reset values
  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic       CARRY_RST = 1'b0;
  localparam logic       PORTC_RST = 1'b1; // latch starts high so a clear is seen

  // power state of the system
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_CLOCK_HOLD,
    PWR_RAM_BACKUP
  } cprb_pwr_e;

  // load from the rest of the core
  typedef struct packed {
    logic             acc_we;
    logic [ACC_W-1:0] acc;
    logic             carry_we;
    logic             carry;
  } cprb_load_s;

  // ram write toward the data memory
  typedef struct packed {
    logic             we;
    logic [DP_W-1:0]  addr;
    logic [ACC_W-1:0] data;
  } cprb_ramwr_s;

endpackage

// File: rtl/cprb_core.sv
`timescale 1ns/1ps
module cprb_core (
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic                           instr_valid,  // instruction to execute
  input  wire logic [cprb_pkg::INSTR_W-1:0]   instr,        // instruction word
  output logic                                instr_ready,  // high while running
  input  wire logic [cprb_pkg::DP_W-1:0]      data_pointer, // nibble address
  input  wire logic [cprb_pkg::ACC_W-1:0]     ram_rdata,    // M(data_pointer)
  input  wire cprb_pkg::cprb_load_s           load,         // core writes acc / carry
  input  wire logic                           wake,         // power control resumes run
  output logic [cprb_pkg::ACC_W-1:0]          acc,          // accumulator
  output logic                                carry_flag,   // carry flag
  output logic                                port_c,       // output port c latch
  output cprb_pkg::cprb_ramwr_s               ram_wr,       // registered ram write
  output logic                                pc_inc,       // advance pc, one cycle
  output cprb_pkg::cprb_pwr_e                 pwr_state     // power state
);

  // ==========================================================
  // overview
  // one instruction is taken per clock while the power state is run;
  // every result below lands one edge after the instruction is taken.
  // the power-down pair is guarded by a one-instruction arm window so
  // that a stray power-down word cannot stop the core by accident.
  // core loads of acc lose to a rotate, loads of carry to a rotate or carry clear in the same cycle.

  // ==========================================================
  // decode
  logic        exec;       // an instruction is taken this cycle
  logic        armed;      // previous executed instruction was the arm
  logic        is_hold;    // clock_hold_instruction
  logic        is_backup;  // ram_backup_instruction
  logic        is_arm;     // power_down_arm_instruction
  logic        is_rotate;  // rotate_right_through_carry
  logic        is_cclr;    // carry_clear
  logic        is_pclr;    // output_port_c_clear
  logic        is_bclr;    // memory_bit_clear
  logic [1:0]  bit_sel;    // bit chosen by the immediate field
  logic [3:0]  clr_mask;   // one-hot bit to clear

  // execution halts outside run; the core must hold the instruction meanwhile
  assign instr_ready = (pwr_state == cprb_pkg::PWR_RUN);
  assign exec        = instr_valid && instr_ready;
  assign is_hold     = exec && (instr == cprb_pkg::OP_CLOCK_HOLD);
  assign is_backup   = exec && (instr == cprb_pkg::OP_RAM_BACKUP);
  assign is_arm      = exec && (instr == cprb_pkg::OP_ARM);
  assign is_rotate   = exec && (instr == cprb_pkg::OP_ROTATE);
  assign is_cclr     = exec && (instr == cprb_pkg::OP_CARRY_CLR);
  assign is_pclr     = exec && (instr == cprb_pkg::OP_PORTC_CLR);
  assign is_bclr     = exec && ((instr & cprb_pkg::BIT_CLR_MASK) == cprb_pkg::OP_BIT_CLR);
  // the bit select is cut from every word; it is only used under is_bclr,
  // so decoding it unconditionally costs nothing
  assign bit_sel     = instr[cprb_pkg::BIT_SEL_LSB +: 2];
  assign clr_mask    = 4'h1 << bit_sel;

  // ==========================================================
  // arming: lasts only to the next executed instruction
  // stall cycles leave the arm alone, only a taken instruction moves it
  always_ff @(posedge clk) begin
    if (srst) begin
      armed <= 1'b0;
    end else if (exec) begin
      // any other instruction between arm and power-down disarms
      armed <= is_arm;
    end
  end

  // ==========================================================
  // power state
  // both power-down states hold until the power control raises wake
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_state <= cprb_pkg::PWR_RUN;
    end else if (pwr_state != cprb_pkg::PWR_RUN) begin
      // only the power control brings the core back
      if (wake) begin
        pwr_state <= cprb_pkg::PWR_RUN;
      end
    end else if (is_hold && armed) begin
      pwr_state <= cprb_pkg::PWR_CLOCK_HOLD;
    end else if (is_backup && armed) begin
      pwr_state <= cprb_pkg::PWR_RAM_BACKUP;
    end
  end

  // ==========================================================
  // program counter advance, every taken instruction is one word
  // registered so the fetch side sees one clean pulse per word
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_inc <= 1'b0;
    end else begin
      // an unarmed ram-backup still advances as a no-operation
      pc_inc <= exec;
    end
  end

  // ==========================================================
  // accumulator
  // rotate has priority; a load in the same cycle would break the shift
  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= cprb_pkg::ACC_RST;
    end else if (is_rotate) begin
      acc <= {carry_flag, acc[3:1]};
    end else if (load.acc_we) begin
      // instructions here win over a core load in the same cycle
      acc <= load.acc;
    end
  end

  // ==========================================================
  // carry flag
  // rotate and carry clear both outrank a core load of the carry
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_flag <= cprb_pkg::CARRY_RST;
    end else if (is_rotate) begin
      carry_flag <= acc[0];
    end else if (is_cclr) begin
      carry_flag <= 1'b0;
    end else if (load.carry_we) begin
      carry_flag <= load.carry;
    end
  end

  // ==========================================================
  // port c latch
  // reset leaves the latch high so that a clear shows on the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      port_c <= cprb_pkg::PORTC_RST;
    end else if (is_pclr) begin
      port_c <= 1'b0;
    end
  end

  // ==========================================================
  // ram bit clear as read-modify-write of the addressed nibble
  // limitation: ram_rdata must be valid in the cycle the word is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      ram_wr <= '0;
    end else begin
      ram_wr.we <= is_bclr;
      if (is_bclr) begin
        // other bits pass through unchanged from the read data
        ram_wr.addr <= data_pointer;
        ram_wr.data <= ram_rdata & ~clr_mask;
      end
    end
  end

  // ==========================================================
  // checks
  // every check is clocked on clk and idle during reset; each one looks
  // one edge after its trigger cycle, where the result first stands
  a_hold_needs_arm: assert property (@(posedge clk) disable iff (srst)
    (pwr_state == cprb_pkg::PWR_RUN) ##1 (pwr_state == cprb_pkg::PWR_CLOCK_HOLD)
    |-> $past(armed) && $past(instr == cprb_pkg::OP_CLOCK_HOLD) && $past(instr_valid))
    else $error("clock hold entered without arming");

  a_hold_entry: assert property (@(posedge clk) disable iff (srst)
    is_hold && armed |=> (pwr_state == cprb_pkg::PWR_CLOCK_HOLD) && !instr_ready)
    else $error("armed clock hold did not stop execution");

  a_backup_entry: assert property (@(posedge clk) disable iff (srst)
    is_backup && armed |=> (pwr_state == cprb_pkg::PWR_RAM_BACKUP) && pc_inc)
    else $error("armed ram backup not entered");

  a_backup_nop: assert property (@(posedge clk) disable iff (srst)
    is_backup && !armed |=> (pwr_state == cprb_pkg::PWR_RUN) && pc_inc
      && $stable(acc) && $stable(port_c))
    else $error("unarmed ram backup was not a no-op");

  a_rotate_value: assert property (@(posedge clk) disable iff (srst)
    is_rotate |=> (acc == {$past(carry_flag), $past(acc[3:1])}) && (carry_flag == $past(acc[0])))
    else $error("rotate through carry wrong");

  a_bit_clear: assert property (@(posedge clk) disable iff (srst)
    is_bclr |=> ram_wr.we && (ram_wr.addr == $past(data_pointer))
      && (ram_wr.data == ($past(ram_rdata) & ~(4'h1 << $past(instr[1:0]))))
      && $stable(carry_flag))
    else $error("bit clear wrote wrong nibble");

  a_carry_clear: assert property (@(posedge clk) disable iff (srst)
    is_cclr |=> !carry_flag && pc_inc)
    else $error("carry clear failed");

  // port clear drops the latch and still counts as one word
  a_port_clear: assert property (@(posedge clk) disable iff (srst)
    is_pclr |=> !port_c && pc_inc)
    else $error("port c clear failed");

  // an unarmed clock hold must leave the core running as a no-operation
  a_hold_unarmed: assert property (@(posedge clk) disable iff (srst)
    is_hold && !armed |=> (pwr_state == cprb_pkg::PWR_RUN) && pc_inc)
    else $error("unarmed clock hold changed power state");

  // while halted nothing may execute, even with a word on offer
  a_hold_no_exec: assert property (@(posedge clk) disable iff (srst)
    !instr_ready |=> !pc_inc && !ram_wr.we)
    else $error("instruction executed outside run");

  // the ram write strobe is a single pulse owned by a bit clear
  a_bit_clear_pulse: assert property (@(posedge clk) disable iff (srst)
    !is_bclr |=> !ram_wr.we)
    else $error("ram write without bit clear");

  // both power-down states resume run one edge after wake
  a_wake_resume: assert property (@(posedge clk) disable iff (srst)
    (pwr_state != cprb_pkg::PWR_RUN) && wake |=> (pwr_state == cprb_pkg::PWR_RUN))
    else $error("wake did not resume run");

  // main scenarios seen by the bench

  c_arm_hold: cover property (@(posedge clk) disable iff (srst)
    is_arm ##1 is_hold ##1 (pwr_state == cprb_pkg::PWR_CLOCK_HOLD));
  c_arm_backup: cover property (@(posedge clk) disable iff (srst)
    is_arm ##1 is_backup ##1 (pwr_state == cprb_pkg::PWR_RAM_BACKUP));
  c_rotate_twice: cover property (@(posedge clk) disable iff (srst)
    is_rotate ##1 is_rotate);
  c_bit_clear: cover property (@(posedge clk) disable iff (srst)
    is_bclr && (bit_sel == 2'h3));
  c_stall_offer: cover property (@(posedge clk) disable iff (srst)
    instr_valid && !instr_ready);

endmodule

// File: testbench/cpu_power_rotate_bit_ops_test.sv
`timescale 1ns/1ps
module cpu_power_rotate_bit_ops_test;
  // ==========================================================
  // stimulus and observed signals
  logic                          clk          = 1'b0;              // 200 mhz clock
  logic                          srst         = 1'b1;              // held for two cycles
  logic                          instr_valid  = 1'b0;              // instruction offered
  logic [cprb_pkg::INSTR_W-1:0]  instr        = cprb_pkg::OP_NOP;  // instruction word
  logic [cprb_pkg::DP_W-1:0]     data_pointer = '0;                // nibble address
  logic [cprb_pkg::ACC_W-1:0]    ram_rdata    = '0;                // nibble at data pointer
  cprb_pkg::cprb_load_s          load         = '0;                // core side loads
  logic                          wake         = 1'b0;              // back to run
  logic                          instr_ready;                      // high in run
  logic [cprb_pkg::ACC_W-1:0]    acc;                              // accumulator
  logic                          carry_flag;                       // carry
  logic                          port_c;                           // port c latch
  cprb_pkg::cprb_ramwr_s         ram_wr;                           // ram write
  logic                          pc_inc;                           // pc advance pulse
  cprb_pkg::cprb_pwr_e           pwr_state;                        // power state
  int                            num_errors   = 0;                 // mismatches seen
  int                            checked      = 0;                 // compares made
  int                            cycles       = 0;                 // timeout counter

  always #2.5 clk = ~clk;

  cprb_core u_dut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .data_pointer(data_pointer), .ram_rdata(ram_rdata),
    .load(load), .wake(wake), .acc(acc), .carry_flag(carry_flag), .port_c(port_c),
    .ram_wr(ram_wr), .pc_inc(pc_inc), .pwr_state(pwr_state));

  // ==========================================================
  // shared helpers
  // case equality, so an unknown output never passes
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // valid stays up after the edge so back to back issues never toggle it twice
  task automatic issue(input logic [9:0] op);
    instr_valid = 1'b1;
    instr       = op;
    @(posedge clk); #1;
  endtask
  task automatic idle();
    instr_valid = 1'b0;
    @(posedge clk); #1;
  endtask
  // acc and carry preset through the core load path, no instruction in flight
  task automatic preset(input logic [3:0] a, input logic c);
    load = '{1'b1, a, 1'b1, c};
    @(posedge clk); #1;
    load = '0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("acc", cprb_pkg::ACC_RST, acc);
    chk("carry", cprb_pkg::CARRY_RST, carry_flag);
    chk("port_c", cprb_pkg::PORTC_RST, port_c);
    chk("ram_we", 1'b0, ram_wr.we);
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
    chk("ready", 1'b1, instr_ready);
  endtask
  // two rotates back to back, carry moving both ways
  task automatic t_rotate();
    preset(4'h9, 1'b0);
    issue(cprb_pkg::OP_ROTATE);
    chk("acc", 4'h4, acc);
    chk("carry", 1'b1, carry_flag);
    issue(cprb_pkg::OP_ROTATE);
    chk("acc", 4'ha, acc);
    chk("carry", 1'b0, carry_flag);
    idle();
  endtask
  task automatic t_clear();
    preset(4'h0, 1'b1);
    issue(cprb_pkg::OP_CARRY_CLR);
    chk("carry", 1'b0, carry_flag);
    chk("pc_inc", 1'b1, pc_inc);
    issue(cprb_pkg::OP_PORTC_CLR);
    chk("port_c", 1'b0, port_c);
    chk("pc_inc", 1'b1, pc_inc);
    idle();
  endtask
  // every bit position; other bits and the carry must survive
  task automatic t_bit_clr();
    preset(4'h0, 1'b1);
    for (int j = 0; j < 4; j++) begin
      data_pointer = 7'h10 + 7'(j);
      ram_rdata    = 4'hf ^ 4'(j << 2);
      issue(cprb_pkg::OP_BIT_CLR | 10'(j));
      chk("ram_we", 1'b1, ram_wr.we);
      chk("ram_addr", 7'h10 + 7'(j), ram_wr.addr);
      chk("ram_data", ram_rdata & ~(4'h1 << j), ram_wr.data);
      chk("carry", 1'b1, carry_flag);
      idle();
      chk("ram_we", 1'b0, ram_wr.we);
    end
  endtask
  // power-down without an arm just before it stays in run
  task automatic t_unarmed();
    issue(cprb_pkg::OP_RAM_BACKUP);
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
    chk("pc_inc", 1'b1, pc_inc);
    issue(cprb_pkg::OP_CLOCK_HOLD);
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
    chk("pc_inc", 1'b1, pc_inc);
    issue(cprb_pkg::OP_ARM);
    issue(cprb_pkg::OP_NOP);
    issue(cprb_pkg::OP_CLOCK_HOLD);
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
    idle();
  endtask
  // armed entries; an instruction offered in hold must be ignored
  task automatic t_armed();
    preset(4'h0, 1'b1);
    issue(cprb_pkg::OP_ARM);
    issue(cprb_pkg::OP_CLOCK_HOLD);
    chk("pwr", cprb_pkg::PWR_CLOCK_HOLD, pwr_state);
    chk("ready", 1'b0, instr_ready);
    instr = cprb_pkg::OP_CARRY_CLR;
    @(posedge clk); #1;
    chk("pc_inc", 1'b0, pc_inc);
    chk("carry", 1'b1, carry_flag);
    instr_valid = 1'b0;
    wake        = 1'b1;
    @(posedge clk); #1;
    wake = 1'b0;
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
    issue(cprb_pkg::OP_ARM);
    issue(cprb_pkg::OP_RAM_BACKUP);
    chk("pwr", cprb_pkg::PWR_RAM_BACKUP, pwr_state);
    chk("pc_inc", 1'b1, pc_inc);
    instr_valid = 1'b0;
    wake        = 1'b1;
    @(posedge clk); #1;
    wake = 1'b0;
    chk("pwr", cprb_pkg::PWR_RUN, pwr_state);
  endtask

  // ==========================================================
  // verdict and hang guard
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run is about 33 cycles; 2000 means something hung
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_rotate();
    t_clear();
    t_bit_clr();
    t_unarmed();
    t_armed();
    end_of_test();
  end
endmodule
